// file: bench/front_end_model.sv
// Behavioural front end: temperature pair, coefficients and volume events
`default_nettype none
module front_end_model
  import heat_energy_pkg::*;
(
  // Clock
  input wire logic       core_clk,
  // Measurements
  output var sample_type sample,
  output var fault_type  fault
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sample = '0;
    fault  = '0;
  end
  // Lines are scrambled between events so a stale value is never mistaken for a live one
  task automatic fire(input logic [TEMP_W-1:0] i, input logic [TEMP_W-1:0] o, input logic [VOL_W-1:0] v,
                      input logic [COEF_W-1:0] ci, input logic [COEF_W-1:0] co);
    @(posedge core_clk);
    sample <= '{i, o, ci, co, v, 1'b1};
    @(posedge core_clk);
    sample <= '{~i, ~o, ~ci, ~co, ~v, 1'b0};
  endtask
  task automatic set_fault(input fault_type f);
    @(posedge core_clk);
    fault <= f;
  endtask
endmodule
`default_nettype wire

// file: bench/heat_energy_accumulator_bench.sv
// Self-checking bench for the heat energy accumulator
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module heat_energy_accumulator_bench
  import heat_energy_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic               core_clk = 1'b0;
  logic               rstn     = 1'b0;
  logic               clkEn    = 1'b1;
  logic [ADDR_W-1:0]  regAddr  = '0;
  logic [DATA_W-1:0]  regWdata = '0;
  logic               regWr    = 1'b0;
  logic               regRd    = 1'b0;
  logic [DATA_W-1:0]  regRdata;
  logic               irq;
  dash_type           dash;
  sample_type         sample;
  fault_type          fault;
  int                 miscompares = 0;
  int                 cmp_count   = 0;
  logic [63:0]        expAcc [NUM_ACC];
  logic [3:0]         ctrlV = '0;
  longint             thrV  = 0;
  longint             refV  = 5000;
  fault_type          fV    = '0;
  logic [DATA_W-1:0]  rd;
  logic [63:0]        rd64;
  // Raw energy per unit: 1e6 per Wh times the unit factor
  localparam logic [63:0] DIVS [4] = '{64'd1000000, 64'd1000000000, 64'd1000000000000, 64'd277800000000};

  always #10 core_clk = ~core_clk;

  heat_energy_accumulator u_heat_energy_accumulator (.core_clk(core_clk), .rstn(rstn), .clkEn(clkEn),
    .sample(sample), .fault(fault), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .irq(irq), .dash(dash));
  front_end_model u_front_end_model (.core_clk(core_clk), .sample(sample), .fault(fault));

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
    #1;
  endtask
  task automatic rdw(input logic [ADDR_W-1:0] a);
    @(posedge core_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1;
    rd = regRdata;
  endtask
  task automatic rd_pair(input logic [ADDR_W-1:0] a);
    rdw(a);
    rd64[31:0] = rd;
    rdw(ADDR_W'(a + 8'h04));
    rd64[63:32] = rd;
  endtask
  task automatic cfg(input logic [3:0] c, input longint t);
    ctrlV = c;
    thrV  = t;
    wr(CTRL_OFFS, 32'(c));
    wr(THRESH_OFFS, {16'h0000, 16'(t)});
  endtask
  task automatic flt(input fault_type f);
    fV = f;
    u_front_end_model.set_fault(f);
  endtask
  task automatic check_all();
    for (int n = 0; n < NUM_ACC; n++) begin
      rd_pair(ADDR_W'(ENERGY_BASE + 8 * n));
      `CHK(rd64, expAcc[n])
    end
  endtask
  task automatic step(input longint i, input longint o, input longint v, input longint ci, input longint co);
    longint k;
    bit     hot;
    k   = ctrlV[2] ? co : ci;
    hot = i > o && (!ctrlV[3] || i > thrV);
    if (fV == '0) begin
      if (hot) expAcc[ACC_HEAT] += 64'(v * (i - o) * k);
      if (hot && refV > o) expAcc[ACC_DISC] += 64'(v * (refV - o) * k);
      if (hot && o > refV) expAcc[ACC_ADD] += 64'(v * (o - refV) * k);
      if (i < o && (!ctrlV[3] || i < thrV)) expAcc[ACC_COOL] += 64'(v * (o - i) * k);
    end
    if (!fV.inlet && !fV.flow) expAcc[ACC_INFWD] += 64'(v * i);
    if (!fV.outlet && !fV.flow) expAcc[ACC_OUTFWD] += 64'(v * o);
    if (!fV.flow) expAcc[ACC_VOLUME] += 64'(v);
    u_front_end_model.fire(TEMP_W'(i), TEMP_W'(o), VOL_W'(v), COEF_W'(ci), COEF_W'(co));
    #1;
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    miscompares++;
    end_of_test();
  end

  initial begin
    for (int n = 0; n < NUM_ACC; n++) expAcc[n] = '0;
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    rdw(REF_OFFS);
    `CHK(rd, 32'h0000_1388)
    check_all();
    wr(8'h3C, 32'hFFFF_FFFF);
    wr(ENERGY_BASE, 32'h1234_5678);
    rdw(8'h3C);
    `CHK(rd, 32'h0000_0000)
    wr(REF_OFFS, 32'h0000_0FA0);
    refV = 4000;
    rdw(REF_OFFS);
    `CHK(rd, 32'h0000_0FA0)
    step(7000, 4000, 10, 11354, 11561);
    step(6000, 3500, 25, 11400, 11500);
    step(5000, 5000, 7, 11000, 11000);
    step(1000, 2000, 12, 11300, 11200);
    step(-500, 300, 9, 11350, 11340);
    check_all();
    cfg(4'h4, 0);
    step(8000, 6000, 10, 11354, 11561);
    step(9000, 3000, 3, 11100, 11900);
    cfg(4'h8, 1500);
    step(1200, 1000, 5, 11000, 11000);
    step(1000, 1200, 6, 11000, 11000);
    step(2000, 2200, 7, 11000, 11000);
    step(1500, 1000, 8, 11000, 11000);
    step(1600, 1000, 4, 11000, 11000);
    check_all();
    wr(MASK_OFFS, 32'h0000_0007);
    `CHK(irq, 1'b0)
    flt('{1'b1, 1'b0, 1'b0});
    step(7000, 3000, 5, 11000, 11100);
    `CHK(irq, 1'b1)
    `CHK(dash, 5'h15)
    flt('{1'b0, 1'b1, 1'b0});
    step(7000, 3000, 5, 11000, 11100);
    `CHK(dash, 5'h0D)
    flt('{1'b0, 1'b0, 1'b1});
    step(7000, 3000, 5, 11000, 11100);
    `CHK(dash, 5'h03)
    rdw(FAULT_OFFS);
    `CHK(rd, 32'h0000_0019)
    check_all();
    rdw(STATUS_OFFS);
    `CHK(rd, 32'h0000_0007)
    @(posedge core_clk);
    clkEn <= 1'b0;
    flt('{1'b0, 1'b0, 1'b0});
    repeat (3) @(posedge core_clk);
    #1;
    `CHK(dash, 5'h03)
    @(posedge core_clk);
    clkEn <= 1'b1;
    wr(MASK_OFFS, 32'h0000_0000);
    `CHK(irq, 1'b0)
    wr(STATUS_OFFS, 32'h0000_0007);
    wr(MASK_OFFS, 32'h0000_0007);
    `CHK(irq, 1'b0)
    `CHK(dash, 5'h00)
    step(20000, 100, 60000, 40000, 40000);
    for (int u = 0; u < 5; u++) begin
      cfg(4'(u % 4), 0);
      // Last pass converts the volume slot, whose divisor is one
      wr(CONV_OFFS, (u == 4) ? 32'h0000_0006 : 32'h0000_0000);
      rdw(CONV_OFFS);
      for (int n = 0; n < 100 && rd[3] !== 1'b0; n++) rdw(CONV_OFFS);
      if (rd[3] !== 1'b0) begin
        miscompares++;
        end_of_test();
      end
      `CHK(rd, (u == 4) ? 32'h0000_0006 : 32'h0000_0000)
      rd_pair(CONV_LO_OFFS);
      `CHK(rd64, (u == 4) ? expAcc[ACC_VOLUME] : expAcc[ACC_HEAT] / DIVS[u % 4])
      rdw(STATUS_OFFS);
      `CHK(rd, 32'h0000_0008)
      wr(STATUS_OFFS, 32'h0000_0008);
    end
    check_all();
    end_of_test();
  end
endmodule
`undef CHK
`default_nettype wire

// file: bench/heat_energy_check_asserts.sv
// Port-level checker for the heat energy accumulator
`default_nettype none
module heat_energy_check
  import heat_energy_pkg::*;
(
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              rstn,
  input wire logic              clkEn,
  // Front end
  input wire sample_type        sample,
  input wire fault_type         fault,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic              regWr,
  input wire logic              regRd,
  input wire logic [DATA_W-1:0] regRdata,
  // Indications
  input wire logic              irq,
  input wire dash_type          dash
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [IRQ_W-1:0] maskCopy;
  // Mask is only visible through port writes, so mirror it here
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      maskCopy <= '0;
    end else if (clkEn && regWr && regAddr == MASK_OFFS) begin
      maskCopy <= regWdata[IRQ_W-1:0];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_dash_inlet: assert property ($past(clkEn) |-> dash.inlet == $past(fault.inlet))
    else $error("inlet dash flag wrong");
  a_dash_outlet: assert property ($past(clkEn) |-> dash.outlet == $past(fault.outlet))
    else $error("outlet dash flag wrong");
  a_dash_flow: assert property ($past(clkEn) |-> dash.flow == $past(fault.flow))
    else $error("flow dash flag wrong");
  a_dash_diff: assert property (dash.diff == (dash.inlet || dash.outlet))
    else $error("difference dash flag wrong");
  a_dash_power: assert property (dash.power == (dash.inlet || dash.outlet || dash.flow))
    else $error("power dash flag wrong");
  a_dash_hold: assert property (!$past(clkEn) |-> $stable(dash))
    else $error("dash flags moved while disabled");
  a_irq_onset: assert property ($rose(fault.inlet) && clkEn && maskCopy[EVT_INLET] |=> ##[0:1] irq)
    else $error("no interrupt after inlet fault");
  a_irq_masked: assert property (maskCopy == '0 |-> !irq)
    else $error("interrupt with all sources masked");
  a_read_idle: assert property ($past(clkEn) && !$past(regRd) |-> regRdata == '0)
    else $error("read data outside read cycle");
  cover property (sample.volPulse && fault.flow);
  cover property ($rose(irq));
  cover property (regRd ##1 regRdata != '0);
endmodule
bind heat_energy_accumulator heat_energy_check u_heat_energy_check (.core_clk(core_clk), .rstn(rstn),
  .clkEn(clkEn), .sample(sample), .fault(fault), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .irq(irq), .dash(dash));
`default_nettype wire

// file: common/heat_energy_pkg.sv
// Constants, register map and carrier types of the heat energy accumulator
//
// Overview of operation
// RULE1 - Discount energy grows by volume times (outlet reference minus outlet temperature) times the heat coefficient.
// RULE2 - Addition energy grows by volume times (outlet minus outlet reference temperature) times the heat coefficient.
// RULE3 - A discount or addition term is added only when its temperature difference is above zero.
// RULE4 - The outlet reference temperature is a writable setting that comes out of reset at 50 degrees Celsius.
// RULE5 - Energy is formed in a watt-hour base as cubic metres times kelvin times coefficient times 1000.
// RULE6 - A reading is converted from watt-hours by 1000 for kWh, 1000000 for MWh and 277800 for GJ.
// RULE7 - Heat energy uses inlet minus outlet temperature and cooling energy uses outlet minus inlet.
// RULE8 - Heat, discount and addition count only while inlet is above outlet; cooling only while inlet is below.
// RULE9 - The heat coefficient is the one taken at the pipe where the flow sensor is mounted.
// RULE10 - With the threshold enabled, heat counts only above it and cooling only below it, judged on inlet.
// RULE11 - A failed measurement stops every register that depends on it while the others keep counting.
// RULE12 - Inlet or outlet failure freezes heat, cooling, discount, addition and its own forwarded register.
// RULE13 - While a failure persists, every reading that depends on it is flagged to be shown as dashes.
// RULE14 - Inlet and outlet forwarded registers grow by volume times inlet and outlet temperature per count.
// RULE15 - All registers update together on each volume event from the temperatures sampled with it.
`default_nettype none
package heat_energy_pkg;
  // Front end formats: 0.01 degC signed, litres, 1e-4 kWh/m3/K
  localparam int TEMP_W        = 16;
  localparam int VOL_W         = 16;
  localparam int COEF_W        = 16;
  localparam int ACC_W_DEFAULT = 64;
  localparam int ADDR_W        = 8;
  localparam int DATA_W        = 32;
  localparam int IRQ_W         = 4;
  localparam int CTRL_W        = 4;
  localparam int NUM_ACC       = 7;
  localparam int ACC_IDX_W     = 3;

  localparam int TEMP_SCALE       = 100;
  localparam int LITRE_PER_M3     = 1000;
  localparam int COEF_SCALE       = 10000;
  localparam int ENERGY_WH_FACTOR = 1000;
  localparam int REF_TEMP_C       = 50;
  localparam logic [TEMP_W-1:0] REF_TEMP_RESET = TEMP_W'(REF_TEMP_C * TEMP_SCALE);
  localparam logic [TEMP_W-1:0] THRESH_RESET   = 16'h0000;

  // Raw product units per watt-hour
  localparam logic [63:0] RAW_PER_WH = 64'(LITRE_PER_M3) * 64'(TEMP_SCALE) * 64'(COEF_SCALE)
                                       / 64'(ENERGY_WH_FACTOR);
  localparam logic [63:0] WH_PER_KWH = 64'd1000;
  localparam logic [63:0] WH_PER_MWH = 64'd1000000;
  localparam logic [63:0] WH_PER_GJ  = 64'd277800;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFFS     = 8'h00;
  localparam logic [ADDR_W-1:0] REF_OFFS      = 8'h04;
  localparam logic [ADDR_W-1:0] THRESH_OFFS   = 8'h08;
  localparam logic [ADDR_W-1:0] STATUS_OFFS   = 8'h0C;
  localparam logic [ADDR_W-1:0] MASK_OFFS     = 8'h10;
  localparam logic [ADDR_W-1:0] CONV_OFFS     = 8'h14;
  localparam logic [ADDR_W-1:0] CONV_LO_OFFS  = 8'h18;
  localparam logic [ADDR_W-1:0] CONV_HI_OFFS  = 8'h1C;
  localparam logic [ADDR_W-1:0] FAULT_OFFS    = 8'h20;
  localparam logic [ADDR_W-1:0] ENERGY_BASE   = 8'h40;
  localparam logic [ADDR_W-1:0] ENERGY_LIMIT  = 8'h78;

  // Status bit positions
  localparam int EVT_INLET  = 0;
  localparam int EVT_OUTLET = 1;
  localparam int EVT_FLOW   = 2;
  localparam int EVT_CONV   = 3;

  typedef enum logic [1:0] {UNIT_WH, UNIT_KWH, UNIT_MWH, UNIT_GJ} unit_type;

  // Accumulator slots
  typedef enum logic [ACC_IDX_W-1:0] {
    ACC_HEAT, ACC_COOL, ACC_INFWD, ACC_OUTFWD, ACC_DISC, ACC_ADD, ACC_VOLUME
  } acc_sel_type;

  typedef struct packed {
    logic     thrEn;
    logic     mountOutlet;
    unit_type unit;
  } ctrl_type;

  typedef struct packed {
    logic signed [TEMP_W-1:0] inlet;
    logic signed [TEMP_W-1:0] outlet;
    logic [COEF_W-1:0]        coefInlet;
    logic [COEF_W-1:0]        coefOutlet;
    logic [VOL_W-1:0]         volume;
    logic                     volPulse;
  } sample_type;

  typedef struct packed {
    logic inlet;
    logic outlet;
    logic flow;
  } fault_type;

  typedef struct packed {
    logic inlet;
    logic outlet;
    logic diff;
    logic flow;
    logic power;
  } dash_type;
endpackage
`default_nettype wire

// file: design/conv_divider.sv
// Sequential restoring divider for unit conversion
`default_nettype none
module conv_divider
  import heat_energy_pkg::*;
#(
  parameter int W = 64
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire logic         clkEn,
  // Request
  input  wire logic         start,
  input  wire logic [W-1:0] dividend,
  input  wire logic [W-1:0] divisor,
  // Result
  output logic [W-1:0]      quotient,
  output logic              busy,
  output logic              done
);
  localparam int CNT_W = $clog2(W + 1);

  if (W < 2) begin : gWidthCheck
    $error("conv_divider needs W of at least 2");
  end

  typedef struct packed {
    logic [W-1:0]     quot;
    logic [W:0]       rem;
    logic [W-1:0]     div;
    logic [CNT_W-1:0] count;
    logic             busy;
    logic             done;
  } div_state_type;

  div_state_type s;
  div_state_type next_s;
  logic [W:0]    shifted;

  assign shifted = {s.rem[W-1:0], s.quot[W-1]};

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (s.busy) begin
      if (shifted >= {1'b0, s.div}) begin
        next_s.rem  = shifted - {1'b0, s.div};
        next_s.quot = {s.quot[W-2:0], 1'b1};
      end else begin
        next_s.rem  = shifted;
        next_s.quot = {s.quot[W-2:0], 1'b0};
      end
      next_s.count = s.count - CNT_W'(1);
      if (s.count == CNT_W'(1)) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end
    end else if (start) begin
      next_s.quot  = dividend;
      next_s.rem   = '0;
      next_s.div   = divisor;
      next_s.count = CNT_W'(W);
      next_s.busy  = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else if (clkEn) begin
      s <= next_s;
    end
  end

  assign quotient = s.quot;
  assign busy     = s.busy;
  assign done     = s.done;
endmodule
`default_nettype wire

// file: design/heat_energy_accumulator.sv
// Energy, volume and forwarded-energy accumulators with register port and fault gating
//
// Our own choices: the address-and-strobe port and the register offsets.
`default_nettype none
module heat_energy_accumulator
  import heat_energy_pkg::*;
#(
  parameter int ACC_W = ACC_W_DEFAULT
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              clkEn,
  // Measurement front end
  input  wire sample_type        sample,
  input  wire fault_type         fault,
  // Register port
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic [DATA_W-1:0]      regRdata,
  // Indications
  output logic                   irq,
  output var dash_type           dash
);
  localparam int DT_W   = TEMP_W + 1;
  localparam int PROD_W = VOL_W + DT_W + COEF_W;

  if (ACC_W < PROD_W + 8 || ACC_W > 64) begin : gAccCheck
    $error("ACC_W must cover a product with headroom and fit two bus words");
  end

  typedef struct packed {
    ctrl_type                         ctrl;
    logic [TEMP_W-1:0]                refTemp;
    logic [TEMP_W-1:0]                threshold;
    logic [IRQ_W-1:0]                 status;
    logic [IRQ_W-1:0]                 mask;
    acc_sel_type                      convSel;
    logic                             convStart;
    logic [NUM_ACC-1:0][ACC_W-1:0]    acc;
    fault_type                        faultPrev;
    dash_type                         dash;
    logic [DATA_W-1:0]                rdata;
    logic                             irq;
  } state_type;

  state_type s;
  state_type next_s;

  logic signed [DT_W-1:0] dHeat;
  logic signed [DT_W-1:0] dCool;
  logic signed [DT_W-1:0] dDisc;
  logic signed [DT_W-1:0] dAdd;
  logic [COEF_W-1:0]      coef;
  logic                   heatOk;
  logic                   coolOk;
  logic                   tempFault;
  logic [ACC_W-1:0]       heatTerm;
  logic [ACC_W-1:0]       coolTerm;
  logic [ACC_W-1:0]       discTerm;
  logic [ACC_W-1:0]       addTerm;
  logic [ACC_W-1:0]       inFwdTerm;
  logic [ACC_W-1:0]       outFwdTerm;
  logic [ACC_W-1:0]       divisor;
  logic [ACC_W-1:0]       quotient;
  logic                   divBusy;
  logic                   divDone;
  logic [ADDR_W-1:0]      accOffs;
  logic [63:0]            accWord;
  logic [63:0]            quotWord;

  function automatic logic [DT_W-1:0] posPart(input logic signed [DT_W-1:0] d);
    posPart = (d > 0) ? d : '0;
  endfunction

  // Raw units: litres x 0.01 K x 1e-4 kWh/m3/K, one millionth of a watt-hour each
  function automatic logic [ACC_W-1:0] energyTerm(input logic [VOL_W-1:0]  v,
                                                  input logic [DT_W-1:0]   dt,
                                                  input logic [COEF_W-1:0] k);
    energyTerm = ACC_W'(v) * ACC_W'(dt) * ACC_W'(k);
  endfunction

  // RULE7 heat and cooling differences
  assign dHeat = DT_W'($signed(sample.inlet)) - DT_W'($signed(sample.outlet));
  assign dCool = DT_W'($signed(sample.outlet)) - DT_W'($signed(sample.inlet));
  // RULE1 discount difference
  assign dDisc = DT_W'($signed(s.refTemp)) - DT_W'($signed(sample.outlet));
  // RULE2 addition difference
  assign dAdd  = DT_W'($signed(sample.outlet)) - DT_W'($signed(s.refTemp));

  // RULE9 mounting coefficient
  assign coef = s.ctrl.mountOutlet ? sample.coefOutlet : sample.coefInlet;

  // RULE8 direction conditions
  // RULE10 threshold gating on inlet
  assign heatOk = (dHeat > 0) && (!s.ctrl.thrEn || $signed(sample.inlet) > $signed(s.threshold));
  assign coolOk = (dHeat < 0) && (!s.ctrl.thrEn || $signed(sample.inlet) < $signed(s.threshold));

  // RULE3 positive differences only
  assign heatTerm = heatOk ? energyTerm(sample.volume, posPart(dHeat), coef) : '0;
  assign coolTerm = coolOk ? energyTerm(sample.volume, posPart(dCool), coef) : '0;
  assign discTerm = heatOk ? energyTerm(sample.volume, posPart(dDisc), coef) : '0;
  assign addTerm  = heatOk ? energyTerm(sample.volume, posPart(dAdd), coef) : '0;

  // RULE14 volume times temperature, signed
  assign inFwdTerm  = ACC_W'($signed(ACC_W'(sample.volume)) * $signed(ACC_W'($signed(sample.inlet))));
  assign outFwdTerm = ACC_W'($signed(ACC_W'(sample.volume)) * $signed(ACC_W'($signed(sample.outlet))));

  assign tempFault = fault.inlet | fault.outlet;

  // RULE6 divisor per selected unit
  // RULE5 raw base scaled to watt-hours
  always_comb begin
    divisor = ACC_W'(64'h1);
    if (s.convSel == ACC_HEAT || s.convSel == ACC_COOL || s.convSel == ACC_DISC || s.convSel == ACC_ADD) begin
      case (s.ctrl.unit)
        UNIT_WH:  divisor = ACC_W'(RAW_PER_WH);
        UNIT_KWH: divisor = ACC_W'(RAW_PER_WH * WH_PER_KWH);
        UNIT_MWH: divisor = ACC_W'(RAW_PER_WH * WH_PER_MWH);
        default:  divisor = ACC_W'(RAW_PER_WH * WH_PER_GJ);
      endcase
    end
  end

  conv_divider #(
    .W (ACC_W)
  ) uDivider (
    .core_clk (core_clk),
    .rstn     (rstn),
    .clkEn    (clkEn),
    .start    (s.convStart),
    .dividend (s.acc[s.convSel]),
    .divisor  (divisor),
    .quotient (quotient),
    .busy     (divBusy),
    .done     (divDone)
  );

  assign accOffs  = regAddr - ENERGY_BASE;
  assign accWord  = 64'(s.acc[accOffs[ACC_IDX_W+2:3]]);
  assign quotWord = 64'(quotient);

  always_comb begin
    logic [IRQ_W-1:0] evt;
    logic [IRQ_W-1:0] clr;
    evt = '0;
    clr = '0;
    next_s = s;
    next_s.convStart = 1'b0;
    next_s.rdata = '0;

    // RULE15 single parallel update per volume event
    if (sample.volPulse) begin
      // RULE11 dependent registers stop, others continue
      // RULE12 freeze map per failure
      if (!tempFault && !fault.flow) begin
        next_s.acc[ACC_HEAT] = s.acc[ACC_HEAT] + heatTerm;
        next_s.acc[ACC_COOL] = s.acc[ACC_COOL] + coolTerm;
        next_s.acc[ACC_DISC] = s.acc[ACC_DISC] + discTerm;
        next_s.acc[ACC_ADD]  = s.acc[ACC_ADD] + addTerm;
      end
      if (!fault.inlet && !fault.flow) begin
        next_s.acc[ACC_INFWD] = s.acc[ACC_INFWD] + inFwdTerm;
      end
      if (!fault.outlet && !fault.flow) begin
        next_s.acc[ACC_OUTFWD] = s.acc[ACC_OUTFWD] + outFwdTerm;
      end
      if (!fault.flow) begin
        next_s.acc[ACC_VOLUME] = s.acc[ACC_VOLUME] + ACC_W'(sample.volume);
      end
    end

    // RULE13 dashed readings while failed
    next_s.dash.inlet  = fault.inlet;
    next_s.dash.outlet = fault.outlet;
    next_s.dash.diff   = tempFault;
    next_s.dash.flow   = fault.flow;
    next_s.dash.power  = tempFault | fault.flow;

    next_s.faultPrev = fault;
    evt[EVT_INLET]  = fault.inlet & ~s.faultPrev.inlet;
    evt[EVT_OUTLET] = fault.outlet & ~s.faultPrev.outlet;
    evt[EVT_FLOW]   = fault.flow & ~s.faultPrev.flow;
    evt[EVT_CONV]   = divDone;

    if (regWr) begin
      if (regAddr == CTRL_OFFS) begin
        next_s.ctrl = ctrl_type'(regWdata[CTRL_W-1:0]);
      end else if (regAddr == REF_OFFS) begin
        // RULE4 reference setting
        next_s.refTemp = regWdata[TEMP_W-1:0];
      end else if (regAddr == THRESH_OFFS) begin
        next_s.threshold = regWdata[TEMP_W-1:0];
      end else if (regAddr == STATUS_OFFS) begin
        clr = regWdata[IRQ_W-1:0];
      end else if (regAddr == MASK_OFFS) begin
        next_s.mask = regWdata[IRQ_W-1:0];
      end else if (regAddr == CONV_OFFS) begin
        // A request during a running division is dropped; the operand must not move under it
        if (!divBusy && !s.convStart && regWdata[ACC_IDX_W-1:0] < ACC_IDX_W'(NUM_ACC)) begin
          next_s.convSel   = acc_sel_type'(regWdata[ACC_IDX_W-1:0]);
          next_s.convStart = 1'b1;
        end
      end
    end

    // Hardware set wins over a same-cycle clear
    next_s.status = (s.status & ~clr) | evt;
    next_s.irq = |(next_s.status & next_s.mask);

    if (regRd) begin
      if (regAddr == CTRL_OFFS) begin
        next_s.rdata = DATA_W'(s.ctrl);
      end else if (regAddr == REF_OFFS) begin
        next_s.rdata = DATA_W'(s.refTemp);
      end else if (regAddr == THRESH_OFFS) begin
        next_s.rdata = DATA_W'(s.threshold);
      end else if (regAddr == STATUS_OFFS) begin
        next_s.rdata = DATA_W'(s.status);
      end else if (regAddr == MASK_OFFS) begin
        next_s.rdata = DATA_W'(s.mask);
      end else if (regAddr == CONV_OFFS) begin
        next_s.rdata = DATA_W'({divBusy | s.convStart, s.convSel});
      end else if (regAddr == CONV_LO_OFFS) begin
        next_s.rdata = quotWord[DATA_W-1:0];
      end else if (regAddr == CONV_HI_OFFS) begin
        next_s.rdata = quotWord[63:DATA_W];
      end else if (regAddr == FAULT_OFFS) begin
        next_s.rdata = DATA_W'({s.dash, fault});
      end else if (regAddr >= ENERGY_BASE && regAddr < ENERGY_LIMIT) begin
        next_s.rdata = accOffs[2] ? accWord[63:DATA_W] : accWord[DATA_W-1:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.refTemp <= REF_TEMP_RESET;
      s.threshold <= THRESH_RESET;
    end else if (clkEn) begin
      s <= next_s;
    end
  end

  assign regRdata = s.rdata;
  assign irq      = s.irq;
  assign dash     = s.dash;
endmodule
`default_nettype wire
